// ==== rtl/ppcr_top.sv ====
// pin configuration, change notification and peripheral remap for one 16-pin port
// ***************************************************
// ***************************************************
//
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "ppcr_defines.svh"

module ppcr_top (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [15:0] reg_rdata,
  input wire logic [15:0] pin_in,
  output logic [15:0] pin_out,
  output logic [15:0] pin_oe,
  output logic [15:0] analog_en,
  output logic [15:0] analog_level,
  output logic [15:0] pullup_en,
  output logic [15:0] pulldown_en,
  output logic [31:0] slew_code,
  input wire logic [3:0] rperi_out,
  input wire logic [3:0] rperi_oe,
  output logic [3:0] rperi_in,
  input wire logic [3:0] fperi_en,
  input wire logic [3:0] fperi_out,
  input wire logic [3:0] fperi_oe,
  output logic [3:0] fperi_in,
  output logic chg_irq,
  output logic remap_locked
);

  // ***************************************************
  // functions
  // ***************************************************
  // output field: 0 is the port itself, 1..4 pick a remappable output
  function automatic logic out_sel_valid(input ppcr_pkg::ppcr_fld_t f);
    out_sel_valid = (f != 4'h0) && (f <= 4'h4);
  endfunction : out_sel_valid

  function automatic logic [1:0] out_sel_idx(input ppcr_pkg::ppcr_fld_t f);
    ppcr_pkg::ppcr_fld_t d;
    d = f - 4'h1;
    out_sel_idx = d[1:0];
  endfunction : out_sel_idx

  // input field: 0 is unassigned and reads low, 1..12 pick remap pin 0..11
  function automatic logic in_pick(input ppcr_pkg::ppcr_fld_t f,
                                   input ppcr_pkg::ppcr_word_t lvl);
    ppcr_pkg::ppcr_fld_t d;
    d = f - 4'h1;
    if (f == 4'h0 || f > 4'hc) begin
      in_pick = 1'b0;
    end else begin
      in_pick = lvl[d];
    end
  endfunction : in_pick

  // ***************************************************
  // registers
  // ***************************************************
  ppcr_pkg::ppcr_word_t dir_r;
  ppcr_pkg::ppcr_word_t latch_r;
  ppcr_pkg::ppcr_word_t ansel_r;
  ppcr_pkg::ppcr_word_t odc_r;
  ppcr_pkg::ppcr_word_t cnen_r;
  ppcr_pkg::ppcr_word_t pu_r;
  ppcr_pkg::ppcr_word_t pd_r;
  ppcr_pkg::ppcr_word_t sr1_r;
  ppcr_pkg::ppcr_word_t sr0_r;
  ppcr_pkg::ppcr_word_t inmap_r;
  ppcr_pkg::ppcr_word_t outmap_lo_r;
  ppcr_pkg::ppcr_word_t outmap_hi_r;
  ppcr_pkg::ppcr_lock_t lock_r;
  ppcr_pkg::ppcr_lock_t lock_nxt;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic [15:0] pin_out_r;
  logic [15:0] pin_oe_r;
  logic [15:0] pin_out_nxt;
  logic [15:0] pin_oe_nxt;
  logic [15:0] analog_en_r;
  logic [15:0] analog_lvl_r;
  logic [15:0] analog_lvl_nxt;
  logic [3:0] rperi_in_r;
  logic [3:0] rperi_in_nxt;
  logic [3:0] fperi_in_r;
  logic chg_irq_r;
  logic locked_r;
  ppcr_chg_if chg ();

  // ***************************************************
  // register decode
  // ***************************************************
  wire wr_dir = reg_we && (reg_addr == `PPCR_OFS_DIR);
  wire wr_latch = reg_we && ((reg_addr == `PPCR_OFS_LATCH) || (reg_addr == `PPCR_OFS_LEVEL));
  wire wr_ansel = reg_we && (reg_addr == `PPCR_OFS_ANSEL);
  wire wr_odc = reg_we && (reg_addr == `PPCR_OFS_ODC);
  wire wr_cnen = reg_we && (reg_addr == `PPCR_OFS_CNEN);
  wire wr_pu = reg_we && (reg_addr == `PPCR_OFS_PU);
  wire wr_pd = reg_we && (reg_addr == `PPCR_OFS_PD);
  wire wr_sr1 = reg_we && (reg_addr == `PPCR_OFS_SR1);
  wire wr_sr0 = reg_we && (reg_addr == `PPCR_OFS_SR0);
  wire wr_chg = reg_we && (reg_addr == `PPCR_OFS_CHG);
  wire wr_lock = reg_we && (reg_addr == `PPCR_OFS_LOCK);
  // remap registers ignore writes only in the locked state; the key1 state still accepts them
  wire map_open = (lock_r != ppcr_pkg::lk_locked);
  wire wr_inmap = reg_we && map_open && (reg_addr == `PPCR_OFS_INMAP);
  wire wr_omlo = reg_we && map_open && (reg_addr == `PPCR_OFS_OUTMAP_LO);
  wire wr_omhi = reg_we && map_open && (reg_addr == `PPCR_OFS_OUTMAP_HI);

  // ***************************************************
  // pin classification
  // ***************************************************
  // analog input: both bits one
  wire [15:0] analog_in = ansel_r & dir_r;
  // peripheral paths and change detection live only where analog select is clear
  wire [15:0] digital = ~ansel_r;
  // level seen by software and by digital peripherals
  wire [15:0] pin_level = pin_in & ~analog_in;
  wire [15:0] dig_level = pin_in & digital;
  wire [31:0] outmap = {outmap_hi_r, outmap_lo_r};

  // ***************************************************
  // lock sequence
  // ***************************************************
  // two keys on back-to-back lock writes reopen the map; any other write between them relocks
  always_comb begin
    lock_nxt = lock_r;
    if (wr_lock) begin
      case (lock_r)
        ppcr_pkg::lk_open: begin
          if (reg_wdata == `PPCR_LOCK_CMD) begin
            lock_nxt = ppcr_pkg::lk_locked;
          end
        end
        ppcr_pkg::lk_locked: begin
          if (reg_wdata == `PPCR_UNLOCK_KEY1) begin
            lock_nxt = ppcr_pkg::lk_key1;
          end
        end
        ppcr_pkg::lk_key1: begin
          if (reg_wdata == `PPCR_UNLOCK_KEY2) begin
            lock_nxt = ppcr_pkg::lk_open;
          end else begin
            lock_nxt = ppcr_pkg::lk_locked;
          end
        end
        default: begin
          lock_nxt = ppcr_pkg::lk_locked;
        end
      endcase
    end else if (reg_we && lock_r == ppcr_pkg::lk_key1) begin
      // any other write between the keys aborts the unlock
      lock_nxt = ppcr_pkg::lk_locked;
    end
  end

  // ***************************************************
  // output drive priority
  // ***************************************************
  // order: analog isolates the peripherals, remap beats fixed, fixed beats port
  always_comb begin
    logic [3:0] fld;
    logic drv;
    logic dat;
    fld = 4'h0;
    drv = 1'b0;
    dat = 1'b0;
    pin_out_nxt = 16'h0000;
    pin_oe_nxt = 16'h0000;
    for (int i = 0; i < `PPCR_NPIN; i++) begin
      drv = ~dir_r[i];
      dat = latch_r[i];
      if (i < `PPCR_NRP) begin
        fld = outmap[4*i +: 4];
      end else begin
        fld = 4'h0;
      end
      if (digital[i] && out_sel_valid(fld)) begin
        // remapped output owns the pin while selected; its peripheral's oe alone decides the drive
        drv = rperi_oe[out_sel_idx(fld)];
        dat = rperi_out[out_sel_idx(fld)];
      end else if (i >= `PPCR_FIX_BASE && digital[i] && fperi_en[i - `PPCR_FIX_BASE]
                   && fperi_oe[i - `PPCR_FIX_BASE]) begin
        drv = 1'b1;
        dat = fperi_out[i - `PPCR_FIX_BASE];
      end
      if (odc_r[i]) begin
        // open drain: pull low only, release for a one
        pin_oe_nxt[i] = drv & ~dat;
        pin_out_nxt[i] = 1'b0;
      end else begin
        pin_oe_nxt[i] = drv;
        pin_out_nxt[i] = dat;
      end
    end
  end

  // analog side sees the pin, or the latch level when the port drives it
  assign analog_lvl_nxt = ansel_r & ((~dir_r & latch_r) | (dir_r & pin_in));

  // ***************************************************
  // input routing
  // ***************************************************
  always_comb begin
    for (int k = 0; k < `PPCR_NPER; k++) begin
      rperi_in_nxt[k] = in_pick(inmap_r[4*k +: 4], dig_level);
    end
  end

  // ***************************************************
  // read mux
  // ***************************************************
  always_comb begin
    rdata_nxt = 16'h0000;
    case (reg_addr)
      `PPCR_OFS_DIR: rdata_nxt = dir_r;
      `PPCR_OFS_LATCH: rdata_nxt = latch_r;
      `PPCR_OFS_LEVEL: rdata_nxt = pin_level;
      `PPCR_OFS_ANSEL: rdata_nxt = ansel_r;
      `PPCR_OFS_ODC: rdata_nxt = odc_r;
      `PPCR_OFS_CNEN: rdata_nxt = cnen_r;
      `PPCR_OFS_PU: rdata_nxt = pu_r;
      `PPCR_OFS_PD: rdata_nxt = pd_r;
      `PPCR_OFS_SR1: rdata_nxt = sr1_r;
      `PPCR_OFS_SR0: rdata_nxt = sr0_r;
      `PPCR_OFS_CHG: rdata_nxt = chg.flags;
      `PPCR_OFS_INMAP: rdata_nxt = inmap_r;
      `PPCR_OFS_OUTMAP_LO: rdata_nxt = outmap_lo_r;
      `PPCR_OFS_OUTMAP_HI: rdata_nxt = outmap_hi_r;
      `PPCR_OFS_LOCK: rdata_nxt = {15'h0000, locked_r};
      default: rdata_nxt = 16'h0000;
    endcase
  end

  // ***************************************************
  // change notification
  // ***************************************************
  // detector runs on clk; a stopped clock in sleep needs the clock kept alive
  assign chg.sample = dig_level;
  assign chg.enable = cnen_r & dir_r & digital;
  assign chg.clear = wr_chg ? reg_wdata : 16'h0000;

  ppcr_chg_det u_chg (
    .clk(clk),
    .arst_n(arst_n),
    .chg(chg)
  );

  // ***************************************************
  // configuration flops
  // ***************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dir_r <= `PPCR_RST_DIR;
      ansel_r <= `PPCR_RST_ANSEL;
      latch_r <= `PPCR_RST_ZERO;
      odc_r <= `PPCR_RST_ZERO;
      cnen_r <= `PPCR_RST_ZERO;
    end else begin
      if (wr_dir) dir_r <= reg_wdata;
      if (wr_ansel) ansel_r <= reg_wdata;
      if (wr_latch) latch_r <= reg_wdata;
      if (wr_odc) odc_r <= reg_wdata;
      if (wr_cnen) cnen_r <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pu_r <= `PPCR_RST_ZERO;
      pd_r <= `PPCR_RST_ZERO;
      sr1_r <= `PPCR_RST_ZERO;
      sr0_r <= `PPCR_RST_ZERO;
    end else begin
      if (wr_pu) pu_r <= reg_wdata;
      if (wr_pd) pd_r <= reg_wdata;
      if (wr_sr1) sr1_r <= reg_wdata;
      if (wr_sr0) sr0_r <= reg_wdata;
    end
  end

  // map registers reset to zero so nothing is routed until assigned
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      inmap_r <= `PPCR_RST_ZERO;
      outmap_lo_r <= `PPCR_RST_ZERO;
      outmap_hi_r <= `PPCR_RST_ZERO;
      lock_r <= ppcr_pkg::lk_open;
    end else begin
      if (wr_inmap) inmap_r <= reg_wdata;
      if (wr_omlo) outmap_lo_r <= reg_wdata;
      if (wr_omhi) outmap_hi_r <= reg_wdata;
      lock_r <= lock_nxt;
    end
  end

  // ***************************************************
  // output flops
  // ***************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_r <= 16'h0000;
      pin_out_r <= 16'h0000;
      pin_oe_r <= 16'h0000;
      analog_en_r <= 16'h0000;
      analog_lvl_r <= 16'h0000;
    end else begin
      rdata_r <= reg_re ? rdata_nxt : 16'h0000;
      pin_out_r <= pin_out_nxt;
      pin_oe_r <= pin_oe_nxt;
      analog_en_r <= ansel_r;
      analog_lvl_r <= analog_lvl_nxt;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rperi_in_r <= 4'h0;
      fperi_in_r <= 4'h0;
      chg_irq_r <= 1'b0;
      locked_r <= 1'b0;
    end else begin
      rperi_in_r <= rperi_in_nxt;
      fperi_in_r <= dig_level[`PPCR_FIX_BASE +: 4];
      chg_irq_r <= |chg.flags;
      locked_r <= (lock_nxt == ppcr_pkg::lk_locked);
    end
  end

  // ***************************************************
  // outputs
  // ***************************************************
  always_comb begin
    for (int j = 0; j < `PPCR_NPIN; j++) begin
      slew_code[2*j +: 2] = {sr1_r[j], sr0_r[j]};
    end
  end

  assign reg_rdata = rdata_r;
  assign pin_out = pin_out_r;
  assign pin_oe = pin_oe_r;
  assign analog_en = analog_en_r;
  assign analog_level = analog_lvl_r;
  assign pullup_en = pu_r;
  assign pulldown_en = pd_r;
  assign rperi_in = rperi_in_r;
  assign fperi_in = fperi_in_r;
  assign chg_irq = chg_irq_r;
  assign remap_locked = locked_r;

endmodule : ppcr_top

`default_nettype wire

// ==== rtl/ppcr_defines.svh ====
// offsets, field positions, reset values and key codes of the pin configuration block
`ifndef PPCR_DEFINES_SVH
`define PPCR_DEFINES_SVH

// ***************************************************
// geometry
// ***************************************************
`define PPCR_NPIN 16
`define PPCR_NRP 8
`define PPCR_NRPI 4
`define PPCR_FIX_BASE 12
`define PPCR_NPER 4
`define PPCR_FLD_W 4

// ***************************************************
// register indices
// ***************************************************
`define PPCR_OFS_DIR 4'h0
`define PPCR_OFS_LATCH 4'h1
`define PPCR_OFS_LEVEL 4'h2
`define PPCR_OFS_ANSEL 4'h3
`define PPCR_OFS_ODC 4'h4
`define PPCR_OFS_CNEN 4'h5
`define PPCR_OFS_PU 4'h6
`define PPCR_OFS_PD 4'h7
`define PPCR_OFS_SR1 4'h8
`define PPCR_OFS_SR0 4'h9
`define PPCR_OFS_CHG 4'ha
`define PPCR_OFS_INMAP 4'hb
`define PPCR_OFS_OUTMAP_LO 4'hc
`define PPCR_OFS_OUTMAP_HI 4'hd
`define PPCR_OFS_LOCK 4'he

// ***************************************************
// reset values
// ***************************************************
`define PPCR_RST_DIR 16'hffff
`define PPCR_RST_ANSEL 16'hffff
`define PPCR_RST_ZERO 16'h0000

// ***************************************************
// lock register codes
// ***************************************************
`define PPCR_LOCK_CMD 16'h00c3
`define PPCR_UNLOCK_KEY1 16'h0055
`define PPCR_UNLOCK_KEY2 16'h00aa
`define PPCR_LOCK_BIT 0

`endif

// ==== rtl/ppcr_pkg.sv ====
// types shared by the pin configuration block
package ppcr_pkg;

  typedef logic [15:0] ppcr_word_t;

  typedef logic [3:0] ppcr_fld_t;

  typedef enum logic [1:0] {
    lk_open,
    lk_locked,
    lk_key1
  } ppcr_lock_t;

endpackage : ppcr_pkg

// ==== rtl/ppcr_chg_if.sv ====
// interface between the top level and the change detector
`timescale 1ns/1ps
`default_nettype none

interface ppcr_chg_if;
  ppcr_pkg::ppcr_word_t sample;
  ppcr_pkg::ppcr_word_t enable;
  ppcr_pkg::ppcr_word_t clear;
  ppcr_pkg::ppcr_word_t flags;

  modport det (
    input sample,
    input enable,
    input clear,
    output flags
  );

  modport ctl (
    output sample,
    output enable,
    output clear,
    input flags
  );
endinterface : ppcr_chg_if

`default_nettype wire

// ==== rtl/ppcr_chg_det.sv ====
// change-of-state detector with sticky per-pin flags
`timescale 1ns/1ps
`default_nettype none

module ppcr_chg_det (
  input wire logic clk,
  input wire logic arst_n,
  ppcr_chg_if.det chg
);

  ppcr_pkg::ppcr_word_t prev_r;
  ppcr_pkg::ppcr_word_t flags_r;
  ppcr_pkg::ppcr_word_t hit;
  ppcr_pkg::ppcr_word_t flags_nxt;

  // compare with last stored level on enabled pins only
  assign hit = (chg.sample ^ prev_r) & chg.enable;
  // a new change beats a clear in the same cycle
  assign flags_nxt = (flags_r & ~chg.clear) | hit;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_r <= 16'h0000;
      flags_r <= 16'h0000;
    end else begin
      prev_r <= chg.sample;
      flags_r <= flags_nxt;
    end
  end

  assign chg.flags = flags_r;

endmodule : ppcr_chg_det

`default_nettype wire

// ==== testbench/ppcr_pin_model.sv ====
// pad model: resolves each pin from the block, an outside driver and the weak pulls
`timescale 1ns/1ps
`default_nettype none

module ppcr_pin_model (
  input wire logic clk,
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe,
  input wire logic [15:0] pullup_en,
  input wire logic [15:0] pulldown_en,
  input wire logic [15:0] ext_oe,
  input wire logic [15:0] ext_val,
  output logic [15:0] pin_in
);
  // a floating pad must not hold its last value, so it toggles every cycle
  logic flt_r = 1'b0;
  always @(posedge clk) begin
    flt_r <= ~flt_r;
  end
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (ext_oe[i]) pin_in[i] = ext_val[i];
      else if (pullup_en[i]) pin_in[i] = 1'b1;
      else if (pulldown_en[i]) pin_in[i] = 1'b0;
      else pin_in[i] = flt_r ^ i[0];
    end
  end
endmodule : ppcr_pin_model

`default_nettype wire

// ==== testbench/ppcr_top_props.sv ====
// port assertions for the pin configuration block
`timescale 1ns/1ps
`default_nettype none
`include "ppcr_defines.svh"

module ppcr_top_props (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  input wire logic [15:0] reg_rdata,
  input wire logic [15:0] pin_in,
  input wire logic [15:0] pullup_en,
  input wire logic [15:0] pulldown_en,
  input wire logic [31:0] slew_code,
  input wire logic chg_irq,
  input wire logic remap_locked
);
  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  logic [15:0] sl_hi_w;
  logic [15:0] sl_lo_w;
  logic clr_w;
  logic clr_r;
  assign clr_w = reg_we && (reg_addr == 4'ha);
  always_comb begin
    for (int j = 0; j < 16; j++) begin
      sl_hi_w[j] = slew_code[2*j+1];
      sl_lo_w[j] = slew_code[2*j];
    end
  end
  // a clear reaches the irq one edge after the flags
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) clr_r <= 1'b0;
    else clr_r <= clr_w;
  end
  // ***************************************************
  // properties
  // ***************************************************
  AST_RDATA_IDLE: assert property (!reg_re |=> reg_rdata == 16'h0000)
    else $error("read data not zero outside read answer");
  AST_SLEW_MSB: assert property (reg_we && reg_addr == 4'h8 |=> sl_hi_w == $past(reg_wdata))
    else $error("slew msb not taken from its register");
  AST_SLEW_LSB: assert property (reg_we && reg_addr == 4'h9 |=> sl_lo_w == $past(reg_wdata))
    else $error("slew lsb not taken from its register");
  AST_PULLUP: assert property (reg_we && reg_addr == 4'h6 |=> pullup_en == $past(reg_wdata))
    else $error("pull-up enables wrong");
  AST_PULLDN: assert property (reg_we && reg_addr == 4'h7 |=> pulldown_en == $past(reg_wdata))
    else $error("pull-down enables wrong");
  AST_CHG_CAUSE: assert property ($rose(chg_irq) |-> $past(pin_in, 2) != $past(pin_in, 3))
    else $error("irq rose without a pin change");
  AST_CHG_STICKY: assert property (chg_irq && !clr_w && !clr_r |=> chg_irq)
    else $error("irq dropped without a clear");
  AST_LOCK_SET: assert property (reg_we && reg_addr == 4'he && reg_wdata == `PPCR_LOCK_CMD |=> remap_locked)
    else $error("lock command did not lock");
  AST_LOCK_HOLD: assert property (remap_locked && !(reg_we && reg_addr == 4'he) |=> remap_locked)
    else $error("lock released without a write");
endmodule : ppcr_top_props

bind ppcr_top ppcr_top_props i_ppcr_top_props (
  .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
  .reg_re(reg_re), .reg_rdata(reg_rdata), .pin_in(pin_in), .pullup_en(pullup_en),
  .pulldown_en(pulldown_en), .slew_code(slew_code), .chg_irq(chg_irq), .remap_locked(remap_locked)
);

`default_nettype wire

// ==== testbench/tb.sv ====
// self-checking testbench for the pin configuration block
`timescale 1ns/1ps
`default_nettype none
`include "ppcr_defines.svh"

module tb;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic [15:0] reg_rdata, pin_in, pin_out, pin_oe, analog_en, analog_level, pullup_en, pulldown_en;
  logic [31:0] slew_code;
  logic [3:0] rperi_out = 4'h0, rperi_oe = 4'h0, fperi_en = 4'h0, fperi_out = 4'h0, fperi_oe = 4'h0;
  logic [3:0] rperi_in, fperi_in;
  logic chg_irq, remap_locked;
  logic [15:0] ext_oe = 16'hffff, ext_val = 16'ha5a5;
  int miscompares = 0;
  int n_compared = 0;

  always #4 clk = ~clk;

  ppcr_top i_ppcr_top (
    .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_re(reg_re), .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .analog_en(analog_en), .analog_level(analog_level), .pullup_en(pullup_en),
    .pulldown_en(pulldown_en), .slew_code(slew_code), .rperi_out(rperi_out), .rperi_oe(rperi_oe),
    .rperi_in(rperi_in), .fperi_en(fperi_en), .fperi_out(fperi_out), .fperi_oe(fperi_oe),
    .fperi_in(fperi_in), .chg_irq(chg_irq), .remap_locked(remap_locked)
  );
  ppcr_pin_model i_ppcr_pin_model (
    .clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en),
    .pulldown_en(pulldown_en), .ext_oe(ext_oe), .ext_val(ext_val), .pin_in(pin_in)
  );

  // ***************************************************
  // bus, compare and closing tasks
  // ***************************************************
  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask : wr
  task automatic rchk(input string what, input logic [3:0] a, input logic [15:0] exp);
    logic [15:0] d;
    @(posedge clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'b0;
    #1;
    d = reg_rdata;
    chk(what, exp, d);
  endtask : rchk
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle
  task automatic drive_ext(input logic [15:0] v);
    @(posedge clk);
    ext_val <= v;
  endtask : drive_ext

  // ***************************************************
  // scenarios
  // ***************************************************
  task automatic t_reset();
    rchk("dir", 4'h0, `PPCR_RST_DIR);
    rchk("ansel", 4'h3, `PPCR_RST_ANSEL);
    rchk("latch", 4'h1, 16'h0000);
    rchk("unmapped", 4'hf, 16'h0000);
    rchk("level", 4'h2, 16'h0000);
    chk("oe", 16'h0000, pin_oe);
    chk("locked", 1'b0, remap_locked);
    $display("test reset done");
  endtask : t_reset
  task automatic t_analog();
    wr(4'h3, 16'h0000);
    settle(2);
    rchk("level", 4'h2, 16'ha5a5);
    chk("fixed in", 4'ha, fperi_in);
    wr(4'h3, 16'h00ff);
    wr(4'h0, 16'hff0f);
    wr(4'h1, 16'h00a0);
    settle(2);
    chk("analog en", 16'h00ff, analog_en);
    chk("analog level", 16'h00a5, analog_level);
    chk("oe", 16'h00f0, pin_oe);
    rchk("level", 4'h2, 16'ha5a0);
    wr(4'h2, 16'h0033);
    rchk("latch", 4'h1, 16'h0033);
    settle(1);
    chk("out", 16'h0030, pin_out & pin_oe);
    $display("test analog done");
  endtask : t_analog
  task automatic t_odc();
    wr(4'h4, 16'h0030);
    settle(2);
    chk("oe", 16'h00c0, pin_oe);
    wr(4'h1, 16'h0000);
    settle(2);
    chk("oe", 16'h00f0, pin_oe);
    chk("out", 16'h0000, pin_out & pin_oe);
    wr(4'h4, 16'h0000);
    $display("test open drain done");
  endtask : t_odc
  task automatic t_pulls();
    wr(4'h3, 16'h0000);
    wr(4'h0, 16'hffff);
    @(posedge clk);
    ext_oe <= 16'hfff3;
    wr(4'h6, 16'h0008);
    wr(4'h7, 16'h0004);
    settle(2);
    chk("pullup", 16'h0008, pullup_en);
    chk("pulldown", 16'h0004, pulldown_en);
    rchk("level", 4'h2, 16'ha5a9);
    for (int c = 0; c < 4; c++) begin
      wr(4'h8, {16{c[1]}});
      wr(4'h9, {16{c[0]}});
      settle(1);
      chk("slew", {16{c[1:0]}}, slew_code);
    end
    @(posedge clk);
    ext_oe <= 16'hffff;
    wr(4'h6, 16'h0000);
    wr(4'h7, 16'h0000);
    $display("test pulls and slew done");
  endtask : t_pulls
  task automatic t_change();
    int k;
    wr(4'h5, 16'h0001);
    settle(3);
    drive_ext(16'ha5a7);
    settle(4);
    chk("irq", 1'b0, chg_irq);
    drive_ext(16'ha5a6);
    for (k = 0; k < 20 && chg_irq !== 1'b1; k++) settle(1);
    if (k == 20) begin
      miscompares++;
      $display("ERROR irq expected 1 seen timeout");
      conclude();
    end
    rchk("flags", 4'ha, 16'h0001);
    settle(4);
    chk("irq", 1'b1, chg_irq);
    wr(4'ha, 16'h0001);
    settle(3);
    chk("irq", 1'b0, chg_irq);
    rchk("flags", 4'ha, 16'h0000);
    wr(4'h5, 16'h0000);
    $display("test change done");
  endtask : t_change
  task automatic t_remap();
    drive_ext(16'h0110);
    wr(4'hb, 16'h0905);
    settle(2);
    chk("remap in", 4'h5, rperi_in);
    drive_ext(16'h0000);
    settle(2);
    chk("remap in", 4'h0, rperi_in);
    wr(4'h0, 16'hfffd);
    wr(4'hc, 16'h0021);
    @(posedge clk);
    rperi_oe <= 4'h3;
    rperi_out <= 4'h3;
    settle(2);
    chk("oe", 16'h0003, pin_oe);
    chk("out", 2'h3, pin_out[1:0]);
    @(posedge clk);
    rperi_oe <= 4'h0;
    settle(2);
    chk("oe", 16'h0000, pin_oe);
    @(posedge clk);
    rperi_oe <= 4'h3;
    wr(4'h3, 16'h0001);
    settle(2);
    chk("oe", 16'h0002, pin_oe);
    wr(4'h3, 16'h0000);
    wr(4'he, `PPCR_LOCK_CMD);
    settle(1);
    chk("locked", 1'b1, remap_locked);
    wr(4'hc, 16'h0000);
    rchk("out map", 4'hc, 16'h0021);
    wr(4'he, `PPCR_UNLOCK_KEY1);
    wr(4'he, `PPCR_UNLOCK_KEY2);
    settle(1);
    chk("locked", 1'b0, remap_locked);
    wr(4'hc, 16'h0000);
    rchk("out map", 4'hc, 16'h0000);
    wr(4'h0, 16'hffff);
    @(posedge clk);
    fperi_en <= 4'h1;
    fperi_oe <= 4'h1;
    fperi_out <= 4'h1;
    ext_val <= 16'h2000;
    settle(2);
    chk("oe", 16'h1000, pin_oe);
    chk("out", 16'h1000, pin_out & pin_oe);
    chk("fixed in", 4'h3, fperi_in);
    $display("test remap done");
  endtask : t_remap

  initial begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_analog();
    t_odc();
    t_pulls();
    t_change();
    t_remap();
    conclude();
  end
endmodule : tb

`default_nettype wire
